// ---- src/fpt_pkg.sv ----
/*
 * constants, register map and state encoding of the flash protection and
 * timing controller.
 * assumes a 32-bit classic wishbone register bus and one clock of up to 50 MHz.
 */
// Functional notes
// [RQ1] 64 KB flash, 1 KB erasable pages
// [RQ2] page erase sets every bit to one
// [RQ3] word program only clears bits
// [RQ4] protection unit covers two pages, 2 KB
// [RQ5] two 32-bit registers hold protection bits
// [RQ6] program-enable zero forbids program and erase
// [RQ7] read-enable zero allows instruction fetch only
// [RQ8] execute-only data reaches fetch path only
// [RQ9] program-enable one, read-enable zero: writable, unreadable
// [RQ10] data read of read-protected unit faults
// [RQ11] blocked program or erase interrupts if masked in
// [RQ12] protection bits start as one
// [RQ13] software may only clear protection bits
// [RQ14] uncommitted clears undone by power-on reset
// [RQ15] commit started from the control register
// [RQ16] timing derived from cycles per microsecond
// [RQ17] reset value suits the maximum clock rate
// [RQ18] software loads MHz minus one first
// [RQ19] program or erase completion raises done event
// [RQ20] writing one to clear register clears event
// [RQ21] address bit zero selects register to commit
// [RQ22] software polls until the write bit clears
// [RQ23] blocked attempt always sets access raw flag
package fpt_pkg;
   // ==================================================================
   // geometry
   localparam int FLASH_WORDS   = 16384;
   localparam int PAGE_WORDS    = 256;
   localparam int UNITS         = 32;
   // ==================================================================
   // register byte offsets
   localparam logic [7:0] OFS_ADDR   = 8'h00;
   localparam logic [7:0] OFS_DATA   = 8'h04;
   localparam logic [7:0] OFS_CTRL   = 8'h08;
   localparam logic [7:0] OFS_RAW    = 8'h0c;
   localparam logic [7:0] OFS_MASK   = 8'h10;
   localparam logic [7:0] OFS_CLR    = 8'h14;
   localparam logic [7:0] OFS_USEC   = 8'h18;
   localparam logic [7:0] OFS_RDEN   = 8'h1c;
   localparam logic [7:0] OFS_PGEN   = 8'h20;
   // ==================================================================
   // control register fields
   localparam logic [15:0] CTRL_KEY  = 16'ha442;
   localparam int CTRL_WRITE_BIT     = 0;
   localparam int CTRL_ERASE_BIT     = 1;
   localparam int CTRL_COMMIT_BIT    = 3;
   // interrupt bit positions
   localparam int IRQ_ACCESS_BIT     = 0;
   localparam int IRQ_DONE_BIT       = 1;
   // ==================================================================
   // reset values and timing
   localparam logic [7:0]  USEC_RST  = 8'h31;
   localparam logic [31:0] PROT_RST  = 32'hffffffff;
   localparam int PROG_TIME_US       = 20;
   localparam int ERASE_TIME_US      = 2000;
   // ==================================================================
   typedef enum logic [1:0] {
      FPT_IDLE = 2'b00,
      FPT_TIME = 2'b01,
      FPT_WIPE = 2'b11
   } fpt_state_e;
endpackage : fpt_pkg

// ---- src/fpt_flash_ctrl.sv ----
/*
 * flash array, program/erase sequencer, protection registers with commit,
 * wishbone register slave and the core's read/fetch port.
 * assumes the core's read port and the bus run on clk_i; rst_i is the
 * power-on reset, nv_factory_i models the factory state of committed bits.
 */
`timescale 1ns/1ps
module fpt_flash_ctrl
   import fpt_pkg::*;
#(
   parameter int PROG_US  = fpt_pkg::PROG_TIME_US,
   parameter int ERASE_US = fpt_pkg::ERASE_TIME_US
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        nv_factory_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        rd_stb_i,
   input  wire logic        rd_fetch_i,
   input  wire logic [13:0] rd_addr_i,
   output logic      [31:0] rd_data_o,
   output logic             rd_ack_o,
   output logic             rd_fault_o,
   output logic             busy_o,
   output logic             irq_o
);
   import fpt_pkg::*;

   if (PROG_US < 1 || PROG_US > 65535 || ERASE_US < 1 || ERASE_US > 65535) begin : g_chk
      $error("fpt_flash_ctrl: operation times must be 1..65535 us");
   end

   // ==================================================================
   // storage
   logic [31:0] mem [0:FLASH_WORDS-1];                 // see [RQ1]
   logic [31:0] addr_r, wdata_r, rd_data_r;
   logic [31:0] pgen_r, rden_r, nv_pgen_r, nv_rden_r;
   logic [7:0]  usec_r, tick_cnt_r;
   logic [15:0] us_left_r;
   logic [7:0]  wipe_cnt_r;
   logic [1:0]  raw_r, mask_r;
   logic [31:0] rdat_r;
   logic        ack_r, rd_ack_r, rd_fault_r;
   logic        op_write_r, op_erase_r, op_commit_r;
   fpt_state_e  state_r;

   logic        bus_req, bus_wr, ctrl_ok, start_ok, blocked, done_ev;
   logic [4:0]  op_unit;

   assign bus_req  = cyc_i & stb_i & ~ack_r;
   assign bus_wr   = bus_req & we_i;
   assign op_unit  = addr_r[15:11];                    // see [RQ4]
   assign ctrl_ok  = bus_wr && adr_i == OFS_CTRL && sel_i == 4'hf && dat_i[31:16] == CTRL_KEY;
   assign start_ok = ctrl_ok && state_r == FPT_IDLE;
   // commit is not a flash content change, so it is never blocked
   assign blocked  = start_ok && !pgen_r[op_unit]
                     && (dat_i[CTRL_WRITE_BIT] || dat_i[CTRL_ERASE_BIT]); // see [RQ6]
   // done lasts one cycle only, so a clear right after completion is never undone
   assign done_ev  = (state_r == FPT_TIME && tick_cnt_r == 8'h00 && us_left_r == 16'h0000 && !op_erase_r)
                     || (state_r == FPT_WIPE && wipe_cnt_r == 8'hff);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge

   // ==================================================================
   // plain software registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_r  <= 32'h00000000;
         wdata_r <= 32'h00000000;
         mask_r  <= 2'b00;
         usec_r  <= USEC_RST;                          // see [RQ17]
      end else if (bus_wr && state_r == FPT_IDLE) begin
         if (adr_i == OFS_ADDR) begin
            addr_r <= merge(addr_r, dat_i, sel_i);
         end else if (adr_i == OFS_DATA) begin
            wdata_r <= merge(wdata_r, dat_i, sel_i);
         end else if (adr_i == OFS_MASK && sel_i[0]) begin
            mask_r <= dat_i[1:0];                      // see [RQ11]
         end else if (adr_i == OFS_USEC && sel_i[0]) begin
            usec_r <= dat_i[7:0];                      // see [RQ16]
         end
      end else if (bus_wr && adr_i == OFS_MASK && sel_i[0]) begin
         mask_r <= dat_i[1:0];
      end
   end

   // ==================================================================
   // protection: live copies reload from committed copies at power-on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pgen_r <= nv_pgen_r;                          // see [RQ14]
         rden_r <= nv_rden_r;
      end else if (bus_wr && adr_i == OFS_PGEN) begin
         pgen_r <= pgen_r & merge(32'hffffffff, dat_i, sel_i); // see [RQ13]
      end else if (bus_wr && adr_i == OFS_RDEN) begin
         rden_r <= rden_r & merge(32'hffffffff, dat_i, sel_i);
      end
   end

   // committed copies survive rst_i; only the factory state sets them
   always_ff @(posedge clk_i) begin
      if (nv_factory_i) begin
         nv_pgen_r <= PROT_RST;                        // see [RQ12]
         nv_rden_r <= PROT_RST;
      end else if (done_ev && op_commit_r) begin
         if (addr_r[0]) begin                          // see [RQ21]
            nv_pgen_r <= nv_pgen_r & pgen_r;           // see [RQ5]
         end else begin
            nv_rden_r <= nv_rden_r & rden_r;
         end
      end
   end

   // ==================================================================
   // sequencer: microsecond tick, then either done or page wipe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r     <= FPT_IDLE;
         op_write_r  <= 1'b0;
         op_erase_r  <= 1'b0;
         op_commit_r <= 1'b0;
         tick_cnt_r  <= 8'h00;
         us_left_r   <= 16'h0000;
         wipe_cnt_r  <= 8'h00;
      end else begin
         case (state_r)
            FPT_IDLE: begin
               if (start_ok && !blocked && dat_i[3:0] != 4'h0) begin // see [RQ15]
                  state_r     <= FPT_TIME;
                  op_write_r  <= dat_i[CTRL_WRITE_BIT];
                  op_erase_r  <= dat_i[CTRL_ERASE_BIT];
                  op_commit_r <= dat_i[CTRL_COMMIT_BIT];
                  tick_cnt_r  <= usec_r;
                  us_left_r   <= dat_i[CTRL_ERASE_BIT] ? 16'(ERASE_US) : 16'(PROG_US);
               end
            end
            FPT_TIME: begin
               if (tick_cnt_r != 8'h00) begin
                  tick_cnt_r <= tick_cnt_r - 8'h01;    // see [RQ16]
               end else if (us_left_r != 16'h0000) begin
                  tick_cnt_r <= usec_r;
                  us_left_r  <= us_left_r - 16'h0001;
               end else if (op_erase_r) begin
                  state_r    <= FPT_WIPE;
                  wipe_cnt_r <= 8'h00;
               end else begin
                  state_r     <= FPT_IDLE;             // see [RQ22]
                  op_write_r  <= 1'b0;
                  op_commit_r <= 1'b0;
               end
            end
            FPT_WIPE: begin
               wipe_cnt_r <= wipe_cnt_r + 8'h01;
               if (wipe_cnt_r == 8'hff) begin
                  state_r    <= FPT_IDLE;
                  op_erase_r <= 1'b0;
               end
            end
            default: state_r <= FPT_IDLE;
         endcase
      end
   end

   // ==================================================================
   // flash array; contents are nonvolatile and so never reset
   always_ff @(posedge clk_i) begin
      if (done_ev && op_write_r) begin
         mem[addr_r[15:2]] <= mem[addr_r[15:2]] & wdata_r; // see [RQ3]
      end else if (state_r == FPT_WIPE) begin
         mem[{addr_r[15:10], wipe_cnt_r}] <= 32'hffffffff; // see [RQ2]
      end
   end

   // ==================================================================
   // interrupt status; a new event wins over a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_r <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == IRQ_ACCESS_BIT && blocked)       // see [RQ23]
                || (i == IRQ_DONE_BIT && done_ev && !op_commit_r)) begin // see [RQ19]
               raw_r[i] <= 1'b1;
            end else if (bus_wr && adr_i == OFS_CLR && sel_i[0] && dat_i[i]) begin
               raw_r[i] <= 1'b0;                       // see [RQ20]
            end
         end
      end
   end

   assign irq_o  = |(raw_r & mask_r);                  // see [RQ11]
   assign busy_o = state_r != FPT_IDLE;

   // ==================================================================
   // wishbone slave: one wait state, unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h00000000;
      end else begin
         ack_r <= bus_req;
         if (bus_req && !we_i) begin
            if (adr_i == OFS_ADDR) begin
               rdat_r <= addr_r;
            end else if (adr_i == OFS_DATA) begin
               rdat_r <= wdata_r;
            end else if (adr_i == OFS_CTRL) begin
               rdat_r <= {28'h0000000, op_commit_r, 1'b0, op_erase_r, op_write_r};
            end else if (adr_i == OFS_RAW) begin
               rdat_r <= {30'h00000000, raw_r};
            end else if (adr_i == OFS_MASK) begin
               rdat_r <= {30'h00000000, mask_r};
            end else if (adr_i == OFS_CLR) begin
               rdat_r <= {30'h00000000, raw_r & mask_r};
            end else if (adr_i == OFS_USEC) begin
               rdat_r <= {24'h000000, usec_r};
            end else if (adr_i == OFS_RDEN) begin
               rdat_r <= rden_r;
            end else if (adr_i == OFS_PGEN) begin
               rdat_r <= pgen_r;
            end else begin
               rdat_r <= 32'h00000000;
            end
         end
      end
   end

   assign ack_o = ack_r;
   assign dat_o = rdat_r;

   // ==================================================================
   // core read port: held off while the array is busy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_ack_r   <= 1'b0;
         rd_fault_r <= 1'b0;
         rd_data_r  <= 32'h00000000;
      end else begin
         rd_ack_r   <= rd_stb_i && !rd_ack_r && state_r == FPT_IDLE;
         rd_fault_r <= 1'b0;
         if (rd_stb_i && !rd_ack_r && state_r == FPT_IDLE) begin
            if (!rd_fetch_i && !rden_r[rd_addr_i[13:9]]) begin // see [RQ7] [RQ8] [RQ9]
               rd_fault_r <= 1'b1;                     // see [RQ10]
               rd_data_r  <= 32'h00000000;
            end else begin
               rd_data_r  <= mem[rd_addr_i];
            end
         end
      end
   end

   assign rd_ack_o   = rd_ack_r;
   assign rd_fault_o = rd_fault_r;
   assign rd_data_o  = rd_data_r;
endmodule : fpt_flash_ctrl

// ---- testbench/fpt_flash_ctrl_properties.sv ----
/* port assertions of the flash controller.
   assumes one clock and the synchronous reset rst_i. */
`timescale 1ns/1ps
module fpt_flash_ctrl_properties (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        rd_stb_i,
   input wire logic        rd_fetch_i,
   input wire logic [31:0] rd_data_o,
   input wire logic        rd_ack_o,
   input wire logic        rd_fault_o,
   input wire logic        busy_o,
   input wire logic        irq_o
);
   // ==================================================================
   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("bus answer not a single pulse");
   a_read_taken: assert property (rd_stb_i && !rd_ack_o && !busy_o && !(cyc_i && stb_i && we_i) |=> rd_ack_o)
      else $error("core read not answered");
   a_fault_data: assert property (rd_fault_o |-> rd_ack_o && !$past(rd_fetch_i))
      else $error("fault on a fetch or without answer");
   a_fault_zero: assert property (rd_fault_o |-> rd_data_o == 32'h00000000)
      else $error("refused read leaked data");
   a_busy_holds: assert property ($past(busy_o) && busy_o |-> !rd_ack_o)
      else $error("read answered during operation");
   a_rdata_hold: assert property (rd_ack_o |=> $stable(rd_data_o))
      else $error("read data moved after answer");
   a_bdata_hold: assert property (ack_o |=> $stable(dat_o))
      else $error("bus data moved after answer");
   a_irq_cause: assert property ($rose(irq_o) && !$past(busy_o) |-> ack_o)
      else $error("interrupt rose without a cause");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !busy_o && !irq_o && !rd_ack_o)
      else $error("outputs active after reset");
endmodule : fpt_flash_ctrl_properties

bind fpt_flash_ctrl fpt_flash_ctrl_properties i_fpt_flash_ctrl_properties (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .rd_stb_i(rd_stb_i),
   .rd_fetch_i(rd_fetch_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o), .rd_fault_o(rd_fault_o),
   .busy_o(busy_o), .irq_o(irq_o));

// ---- testbench/fpt_core_model.sv ----
/* processor core model: issues fetches and data reads one word at a time.
   assumes the controller answers with a one-cycle rd_ack_i pulse. */
`timescale 1ns/1ps
module fpt_core_model (
   input  wire logic        clk_i,
   output logic             rd_stb_o,
   output logic             rd_fetch_o,
   output logic      [13:0] rd_addr_o,
   input  wire logic [31:0] rd_data_i,
   input  wire logic        rd_ack_i,
   input  wire logic        rd_fault_i
);
   initial begin
      rd_stb_o   = 1'b0;
      rd_fetch_o = 1'b0;
      rd_addr_o  = 14'h0;
   end
   // ==================================================================
   // one read; request held until the answer is sampled
   task automatic read(input logic [13:0] a, input logic f, output logic [31:0] d, output logic fl);
      rd_stb_o   <= 1'b1;
      rd_fetch_o <= f;
      rd_addr_o  <= a;
      @(posedge clk_i);
      while (rd_ack_i !== 1'b1) @(posedge clk_i);
      d = rd_data_i;
      fl = rd_fault_i;
      rd_stb_o  <= 1'b0;
      // released address shows no stale value
      rd_addr_o <= ~a;
      @(posedge clk_i);
   endtask : read
endmodule : fpt_core_model

// ---- testbench/fpt_flash_ctrl_tb.sv ----
/* self-checking bench of the flash controller.
   assumes short timing parameters; registers reached over wishbone. */
`timescale 1ns/1ps
module fpt_flash_ctrl_tb;
   import fpt_pkg::*;
   logic        clk_i = 0, rst_i = 1, nv_factory_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, v, d;
   logic        f;
   wire logic [31:0] dat_o, rd_data_o;
   wire logic [13:0] rd_addr_i;
   wire logic        ack_o, rd_stb_i, rd_fetch_i, rd_ack_o, rd_fault_o, busy_o, irq_o;
   int          err_count = 0, checks_done = 0, cycles = 0, busy_cnt = 0, busy_len = 0;
   // short operation times keep the run small
   localparam int PROG_T  = 2;
   localparam int ERASE_T = 3;
   fpt_flash_ctrl #(.PROG_US(PROG_T), .ERASE_US(ERASE_T)) i_fpt_flash_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .nv_factory_i(nv_factory_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rd_stb_i(rd_stb_i), .rd_fetch_i(rd_fetch_i),
      .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o), .rd_fault_o(rd_fault_o),
      .busy_o(busy_o), .irq_o(irq_o));
   fpt_core_model i_fpt_core_model (.clk_i(clk_i), .rd_stb_o(rd_stb_i), .rd_fetch_o(rd_fetch_i),
      .rd_addr_o(rd_addr_i), .rd_data_i(rd_data_o), .rd_ack_i(rd_ack_o), .rd_fault_i(rd_fault_o));
   always #25 clk_i = ~clk_i;
   // ==================================================================
   // tasks
   task report_and_stop;
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= wd;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      v = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(n, e, v);
   endtask : rdchk
   // start an operation, check whether it started, poll until its busy flags clear
   task op(input logic [31:0] cmd, input logic run);
      wb(1'b1, OFS_CTRL, cmd);
      chk("busy", {31'h0, run}, {31'h0, busy_o});
      do wb(1'b0, OFS_CTRL, 32'h0); while (v[3:0] !== 4'h0);
   endtask : op
   task do_reset(input logic nv);
      rst_i <= 1'b1;
      nv_factory_i <= nv;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      nv_factory_i <= 1'b0;
   endtask : do_reset
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // length in cycles of the last busy period, for the timing checks
   always @(posedge clk_i) begin
      if (busy_o === 1'b1) begin
         busy_cnt++;
      end else if (busy_cnt != 0) begin
         busy_len = busy_cnt;
         busy_cnt = 0;
      end
   end
   // ==================================================================
   // sequence
   initial begin
      do_reset(1'b1);
      rdchk("usec", OFS_USEC, {24'h000000, USEC_RST});
      rdchk("pgen", OFS_PGEN, PROT_RST);
      rdchk("rden", OFS_RDEN, PROT_RST);
      rdchk("unmapped", 8'h40, 32'h00000000);
      wb(1'b1, OFS_USEC, 32'h00000001);
      wb(1'b1, OFS_ADDR, 32'h00000000);
      op(32'h00000002, 1'b0);
      op(32'ha4420002, 1'b1);
      chk("erase_time", 32'((ERASE_T + 1) * 2 + PAGE_WORDS), busy_len);
      i_fpt_core_model.read(14'h0000, 1'b0, d, f);
      chk("erased", 32'hffffffff, d);
      wb(1'b1, OFS_DATA, 32'h12345678);
      op(32'ha4420001, 1'b1);
      chk("prog_time", 32'((PROG_T + 1) * 2), busy_len);
      wb(1'b1, OFS_DATA, 32'hffff0000);
      op(32'ha4420001, 1'b1);
      i_fpt_core_model.read(14'h0000, 1'b0, d, f);
      chk("programmed", 32'h12340000, d);
      rdchk("raw_done", OFS_RAW, 32'h00000002);
      wb(1'b1, OFS_CLR, 32'h00000002);
      rdchk("raw_cleared", OFS_RAW, 32'h00000000);
      wb(1'b1, OFS_PGEN, 32'hfffffffe);
      wb(1'b1, OFS_PGEN, 32'hffffffff);
      rdchk("pgen_clear_only", OFS_PGEN, 32'hfffffffe);
      wb(1'b1, OFS_MASK, 32'h00000001);
      wb(1'b1, OFS_DATA, 32'h00000000);
      op(32'ha4420001, 1'b0);
      op(32'ha4420002, 1'b0);
      chk("irq", 32'h00000001, {31'h0, irq_o});
      rdchk("raw_access", OFS_RAW, 32'h00000001);
      rdchk("masked", OFS_CLR, 32'h00000001);
      i_fpt_core_model.read(14'h0000, 1'b0, d, f);
      chk("kept", 32'h12340000, d);
      wb(1'b1, OFS_CLR, 32'h00000001);
      chk("irq_cleared", 32'h00000000, {31'h0, irq_o});
      wb(1'b1, OFS_RDEN, 32'hfffffffc);
      i_fpt_core_model.read(14'h0100, 1'b0, d, f);
      chk("fault_page1", 32'h00000001, {31'h0, f});
      i_fpt_core_model.read(14'h0000, 1'b0, d, f);
      chk("fault", 32'h00000001, {31'h0, f});
      chk("fault_data", 32'h00000000, d);
      i_fpt_core_model.read(14'h0000, 1'b1, d, f);
      chk("fetch", 32'h12340000, d);
      chk("fetch_ok", 32'h00000000, {31'h0, f});
      wb(1'b1, OFS_ADDR, 32'h00000800);
      op(32'ha4420002, 1'b1);
      i_fpt_core_model.read(14'h0200, 1'b1, d, f);
      chk("wr_only_erase", 32'hffffffff, d);
      i_fpt_core_model.read(14'h0200, 1'b0, d, f);
      chk("wr_only_fault", 32'h00000001, {31'h0, f});
      wb(1'b1, OFS_ADDR, 32'h00000000);
      op(32'ha4420008, 1'b1);
      sel_i <= 4'he;
      wb(1'b1, OFS_PGEN, 32'h00000000);
      sel_i <= 4'hf;
      rdchk("pgen_lanes", OFS_PGEN, 32'h000000fe);
      do_reset(1'b0);
      rdchk("rden_committed", OFS_RDEN, 32'hfffffffc);
      rdchk("pgen_restored", OFS_PGEN, PROT_RST);
      wb(1'b1, OFS_PGEN, 32'h7fffffff);
      wb(1'b1, OFS_ADDR, 32'h00000001);
      op(32'ha4420008, 1'b1);
      do_reset(1'b0);
      rdchk("pgen_committed", OFS_PGEN, 32'h7fffffff);
      rdchk("rden_kept", OFS_RDEN, 32'hfffffffc);
      report_and_stop();
   end
endmodule : fpt_flash_ctrl_tb
